//--- hdl/ebr_ctrl.sv
// external bus controller: retry, halt, three-wire arbitration, show cycles
`include "ebr_params.svh"

// Function
// [R01] bus error plus halt starts retry
// [R02] retry: strobes off, wait both negated
// [R03] rerun same address, codes, control, data
// [R04] far side drops bus error before S2
// [R05] request with retry: grant bus first
// [R06] locked indication held through retry
// [R07] never release bus while locked
// [R08] far side uses error plus request only
// [R09] halt stops bus after acknowledge
// [R10] halt spares internal work, blocks interrupts
// [R11] bus error under halt means retry
// [R12] halted: data tri-state, outputs held; internal accesses still load the address and show cycles drive data
// [R13] foreign master: tri-state, then restore
// [R14] arbitration always served, lowest priority
// [R15] request, grant, acknowledge in order
// [R16] grant only at boundary, never locked
// [R17] master holds acknowledge while owning
// [R18] master waits for grant, idle acknowledge
// [R19] grant drops after acknowledge, re-grants
// [R20] show off: follow addresses, no strobes
// [R21] show on: data strobe, data driven
// [R22] size shows lanes; byte duplicated
// [R23] control pins synchronised first
// [R24] show field stall encoding defined
module ebr_ctrl #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int RESYNC_CYC = `EBR_RESYNC_CYC,
  parameter int GRANT_GAP_CYC = `EBR_GRANT_GAP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_acc_req,
  input wire logic i_acc_internal,
  input wire logic i_acc_locked,
  input wire logic i_acc_rw,
  input wire logic [ADDR_W-1:0] i_acc_addr,
  input wire logic [2:0] i_acc_fc,
  input wire logic [1:0] i_acc_siz,
  input wire logic [DATA_W-1:0] i_acc_wdata,
  input wire logic [DATA_W-1:0] i_acc_idata,
  output logic o_acc_done,
  output logic o_acc_bus_error_in,
  output logic [DATA_W-1:0] o_acc_rdata,
  output logic o_irq_hold,
  input wire logic [1:0] i_show_cycle_enable,
  input wire logic i_transfer_ack_b,
  input wire logic i_bus_error_in_b,
  input wire logic i_halt_b,
  input wire logic i_bus_request_b,
  input wire logic i_grant_acknowledge_b,
  output logic o_bus_grant_b,
  output logic o_address_strobe_b,
  output logic o_data_strobe_b,
  output logic o_locked_cycle_b,
  output logic o_ctrl_oe,
  output logic [ADDR_W-1:0] o_addr,
  output logic [2:0] o_fc,
  output logic [1:0] o_byte_count_code,
  output logic o_rw,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe
);

  initial begin
    if (DATA_W != 16 || ADDR_W < 1 || ADDR_W > 32) begin
      $error("ebr_ctrl: unsupported bus width");
    end
    if (RESYNC_CYC < 1 || RESYNC_CYC > 255 || GRANT_GAP_CYC < 1 || GRANT_GAP_CYC > 255) begin
      $error("ebr_ctrl: delay count out of range");
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [4:0] pins_b;
  logic [4:0] pins_s;
  logic ack_s;
  logic bus_error_in_s;
  logic halt_s;
  logic br_s;
  logic grant_acknowledge_s;

  assign pins_b = {i_grant_acknowledge_b, i_bus_request_b, i_halt_b,
                   i_bus_error_in_b, i_transfer_ack_b};

  ebr_sync #(
    .WIDTH(5),
    .RST_VAL(16'h001f)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_async(pins_b),
    .o_sync(pins_s)
  ); // R23

  assign ack_s = ~pins_s[0];
  assign bus_error_in_s = ~pins_s[1];
  assign halt_s = ~pins_s[2];
  assign br_s = ~pins_s[3];
  assign grant_acknowledge_s = ~pins_s[4];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  ebr_pkg::ebr_state_t state_r;
  ebr_pkg::ebr_state_t state_nxt;
  ebr_pkg::ebr_show_t show_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2:0] fc_r;
  logic [1:0] siz_r;
  logic rw_r;
  logic [DATA_W-1:0] dout_r;
  logic locked_r;
  logic [7:0] sync_cnt_r;
  logic [7:0] gap_cnt_r;
  logic bg_r;
  logic grant_acknowledge_d_r;
  logic done_r;
  logic bus_error_in_res_r;
  logic [DATA_W-1:0] rdata_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire idle = (state_r == ebr_pkg::ST_IDLE);
  // a lock arriving with the request counts at once, so no grant slips in
  wire lock_now = idle ? (i_acc_locked && i_acc_req) : locked_r; // R07
  // lowest priority: an unlocked pending request wins over a new start
  wire grant_due = br_s && !lock_now; // R14
  wire show_on = (show_r != ebr_pkg::EBR_SHOW_OFF); // R21
  // stall code holds internal work back, with no start at all, while a master owns the bus
  wire int_stall = (show_r == ebr_pkg::EBR_SHOW_STALL) && grant_acknowledge_s; // R24
  // halt gates only external starts, internal work runs on
  wire ext_start = idle && i_acc_req && !i_acc_internal && !halt_s
                   && !grant_acknowledge_s && !bg_r && !grant_due; // R09 R10 R14
  wire int_start = idle && i_acc_req && i_acc_internal && !int_stall; // R10
  wire retry_hit = bus_error_in_s && halt_s; // R01 R11
  wire retry_free = !bus_error_in_s && !halt_s && !grant_acknowledge_s && !bg_r && !grant_due; // R02 R05
  // boundary: between operand transfers or parked in retry
  wire boundary = idle || (state_r == ebr_pkg::ST_RETRY); // R16
  wire may_grant = grant_due && boundary; // R07 R14 R16
  wire grant_acknowledge_edge = grant_acknowledge_s ^ grant_acknowledge_d_r;
  wire byte_wr = (i_acc_siz == `EBR_SIZ_BYTE) && !i_acc_rw;
  wire [DATA_W-1:0] ext_wdata = byte_wr ? {2{i_acc_wdata[7:0]}} : i_acc_wdata; // R22
  wire load_addr = ext_start || (int_start && !grant_acknowledge_s); // R20 R13

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ebr_pkg::ST_IDLE: begin
        if (ext_start) begin
          state_nxt = ebr_pkg::ST_ADDR;
        end else if (int_start) begin
          state_nxt = ebr_pkg::ST_SHOW;
        end
      end
      ebr_pkg::ST_ADDR: begin
        state_nxt = ebr_pkg::ST_DATA;
      end
      ebr_pkg::ST_DATA: begin
        if (retry_hit) begin
          state_nxt = ebr_pkg::ST_RETRY; // R01 R11
        end else if (bus_error_in_s || ack_s) begin
          state_nxt = ebr_pkg::ST_TERM;
        end
      end
      ebr_pkg::ST_TERM: begin
        // late error with halt after acknowledge is a delayed retry
        if (retry_hit) begin
          state_nxt = ebr_pkg::ST_RETRY; // R01
        end else begin
          state_nxt = ebr_pkg::ST_IDLE;
        end
      end
      ebr_pkg::ST_RETRY: begin
        if (retry_free) begin
          state_nxt = ebr_pkg::ST_RESYNC; // R02 R05
        end
      end
      ebr_pkg::ST_RESYNC: begin
        if (sync_cnt_r == 8'h01) begin
          state_nxt = ebr_pkg::ST_ADDR; // R03
        end
      end
      ebr_pkg::ST_SHOW: begin
        state_nxt = ebr_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = ebr_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ebr_pkg::ST_IDLE;
      show_r <= ebr_pkg::ebr_show_t'(`EBR_SHOW_RST); // R20
      sync_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      show_r <= ebr_pkg::ebr_show_t'(i_show_cycle_enable);
      if (state_r == ebr_pkg::ST_RETRY) begin
        sync_cnt_r <= 8'(RESYNC_CYC);
      end else if (sync_cnt_r != 8'h00) begin
        sync_cnt_r <= sync_cnt_r - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // cycle attributes; untouched during retry so the rerun matches
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_r <= '0;
      fc_r <= 3'h0;
      siz_r <= 2'h0;
      rw_r <= 1'b1;
      dout_r <= 16'h0000;
    end else if (load_addr) begin
      addr_r <= i_acc_addr; // R03 R20
      fc_r <= i_acc_fc;
      siz_r <= i_acc_siz; // R22
      rw_r <= i_acc_rw;
      dout_r <= i_acc_internal ? i_acc_idata : ext_wdata; // R21 R22
    end else if (int_start) begin
      dout_r <= i_acc_idata;
    end
  end

  // ---------------------------------------------------------------
  // locked indication: sampled only while idle
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      locked_r <= 1'b0;
    end else if (idle) begin
      locked_r <= i_acc_locked && i_acc_req; // R06
    end
  end

  // ---------------------------------------------------------------
  // completion to the core
  // ---------------------------------------------------------------
  wire ext_done = (state_r == ebr_pkg::ST_TERM) && !retry_hit;
  wire int_done = (state_r == ebr_pkg::ST_SHOW);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_r <= 1'b0;
      bus_error_in_res_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      done_r <= ext_done || int_done;
      if (ext_done || int_done) begin
        bus_error_in_res_r <= ext_done && bus_error_in_s;
      end
      if (state_r == ebr_pkg::ST_DATA && ack_s && !bus_error_in_s && rw_r) begin
        rdata_r <= i_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bg_r <= 1'b0;
      grant_acknowledge_d_r <= 1'b0;
      gap_cnt_r <= 8'h00;
    end else begin
      grant_acknowledge_d_r <= grant_acknowledge_s;
      if (grant_acknowledge_edge) begin
        bg_r <= 1'b0; // R19
        gap_cnt_r <= 8'(GRANT_GAP_CYC);
      end else if (gap_cnt_r != 8'h00) begin
        bg_r <= 1'b0;
        gap_cnt_r <= gap_cnt_r - 8'h01;
      end else begin
        // pending requests get a fresh grant for early selection
        bg_r <= may_grant; // R15 R19
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  wire ext_active = (state_r == ebr_pkg::ST_ADDR) || (state_r == ebr_pkg::ST_DATA);
  wire show_act = int_done && show_on && !grant_acknowledge_s; // R21

  assign o_bus_grant_b = ~bg_r; // R15
  assign o_address_strobe_b = ~ext_active; // R02 R12 R21
  assign o_data_strobe_b = ~((ext_active && (rw_r || state_r == ebr_pkg::ST_DATA))
                             || show_act); // R02 R20 R21
  assign o_locked_cycle_b = ~locked_r; // R06
  assign o_ctrl_oe = !grant_acknowledge_s; // R13
  assign o_addr = addr_r; // R12 R13
  assign o_fc = fc_r;
  assign o_byte_count_code = siz_r;
  assign o_rw = rw_r;
  assign o_data = dout_r;
  assign o_data_oe = (ext_active && !rw_r) || show_act; // R12 R20
  assign o_irq_hold = halt_s; // R10
  assign o_acc_done = done_r;
  assign o_acc_bus_error_in = bus_error_in_res_r;
  assign o_acc_rdata = rdata_r;

endmodule

//--- hdl/ebr_params.svh
// constants for the external bus retry, halt and arbitration controller
`ifndef EBR_PARAMS_SVH
`define EBR_PARAMS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define EBR_CLK_PERIOD_NS 100
`define EBR_RESYNC_NS 200
`define EBR_RESYNC_CYC ((`EBR_RESYNC_NS + `EBR_CLK_PERIOD_NS - 1) / `EBR_CLK_PERIOD_NS)
`define EBR_GRANT_GAP_NS 200
`define EBR_GRANT_GAP_CYC ((`EBR_GRANT_GAP_NS + `EBR_CLK_PERIOD_NS - 1) / `EBR_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// reset values and field codes
// ---------------------------------------------------------------
`define EBR_SHOW_RST 2'h0
`define EBR_SIZ_BYTE 2'h1
`define EBR_SIZ_WORD 2'h2
`define EBR_SYNC_STAGES 2

`endif

//--- hdl/ebr_pkg.sv
// types shared by the external bus retry, halt and arbitration controller
package ebr_pkg;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_TERM,
    ST_RETRY,
    ST_RESYNC,
    ST_SHOW
  } ebr_state_t;

  // ---------------------------------------------------------------
  // show-cycle field encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EBR_SHOW_OFF = 2'h0,
    EBR_SHOW_ON = 2'h1,
    EBR_SHOW_RSVD = 2'h2,
    EBR_SHOW_STALL = 2'h3
  } ebr_show_t;

endpackage

//--- hdl/ebr_sync.sv
// two-flop synchroniser bank for asynchronous bus control pins
module ebr_sync #(
  parameter int WIDTH = 5,
  parameter logic [15:0] RST_VAL = 16'h001f
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  initial begin
    if (WIDTH < 1 || WIDTH > 16) begin
      $error("ebr_sync: WIDTH out of range");
    end
  end

  // ---------------------------------------------------------------
  // per-bit stages; first flop feeds only the second
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic meta_r;
      logic stab_r;
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r <= RST_VAL[gi];
          stab_r <= RST_VAL[gi];
        end else begin
          meta_r <= i_async[gi];
          stab_r <= meta_r;
        end
      end
      assign o_sync[gi] = stab_r;
    end
  endgenerate

endmodule

//--- tb/ebr_ctrl_checker.sv
// port-level assertions for the external bus controller
module ebr_ctrl_checker #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_acc_req,
  input wire logic i_acc_internal,
  input wire logic [1:0] i_show_cycle_enable,
  input wire logic i_bus_error_in_b,
  input wire logic i_halt_b,
  input wire logic i_bus_request_b,
  input wire logic i_grant_acknowledge_b,
  input wire logic o_bus_grant_b,
  input wire logic o_address_strobe_b,
  input wire logic o_data_strobe_b,
  input wire logic o_locked_cycle_b,
  input wire logic o_ctrl_oe,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [1:0] o_byte_count_code,
  input wire logic o_rw,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_irq_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  AST_GRANT_UNLOCKED: assert property (!o_bus_grant_b |-> o_locked_cycle_b)
    else $error("grant while locked");
  AST_RETRY_OFF: assert property ((!i_bus_error_in_b && !i_halt_b && !o_address_strobe_b)
    |-> ##[1:5] (o_address_strobe_b && o_data_strobe_b)) else $error("retry kept strobes");
  AST_NO_START_HALTED: assert property ($fell(o_address_strobe_b) |-> $past(i_halt_b, 3))
    else $error("cycle started under halt");
  AST_HALT_QUIET: assert property ((!i_halt_b && i_show_cycle_enable == 2'h0) [*8]
    |-> (o_address_strobe_b && o_data_strobe_b && !o_data_oe)) else $error("halt not quiet");
  AST_HALT_HOLD: assert property ((!i_halt_b && !i_acc_req) [*8] |->
    ($stable(o_addr) && $stable(o_rw) && $stable(o_byte_count_code))) else $error("moved");
  AST_IRQ_HOLD: assert property (!i_halt_b [*4] |-> o_irq_hold)
    else $error("interrupts open while halted");
  AST_MASTER_OFF: assert property (!i_grant_acknowledge_b [*4] |-> !o_ctrl_oe && !o_data_oe)
    else $error("drives under other master");
  AST_GRANT_DROP: assert property ($changed(i_grant_acknowledge_b) |-> ##[1:5] o_bus_grant_b)
    else $error("grant kept");
  AST_GRANT_GIVEN: assert property ((!i_bus_request_b && i_grant_acknowledge_b
    && !i_acc_req) [*3] |-> ##[0:6] !o_bus_grant_b) else $error("no grant");
  AST_SHOW_ON: assert property (($rose(i_acc_req) && i_acc_internal
    && i_show_cycle_enable == 2'h1) |-> ##[1:2] (!o_data_strobe_b && o_address_strobe_b))
    else $error("show cycle missing");
  AST_BYTE_DUP: assert property ((!o_data_strobe_b && o_data_oe && !o_rw
    && o_byte_count_code == 2'h1) |-> o_data[15:8] == o_data[7:0]) else $error("byte lanes");
  cover property (!i_bus_error_in_b && !i_halt_b);
  cover property (!o_bus_grant_b ##[1:4] !i_grant_acknowledge_b);
  cover property (!o_data_strobe_b && o_address_strobe_b);
endmodule

bind ebr_ctrl ebr_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.i_sys_clk, .i_rst_b,
  .i_acc_req, .i_acc_internal, .i_show_cycle_enable, .i_bus_error_in_b, .i_halt_b,
  .i_bus_request_b, .i_grant_acknowledge_b, .o_bus_grant_b, .o_address_strobe_b,
  .o_data_strobe_b, .o_locked_cycle_b, .o_ctrl_oe, .o_addr, .o_byte_count_code, .o_rw,
  .o_data, .o_data_oe, .o_irq_hold);

//--- tb/ebr_far_model.sv
// behavioural external slave and bus master facing the bus controller
module ebr_far_model #(
  parameter logic [15:0] RD = 16'ha5c3
) (
  input wire logic i_clk,
  input wire logic i_as_b,
  input wire logic i_rw,
  input wire logic i_grant_b,
  input wire logic i_slow,
  input wire logic i_retry,
  input wire logic i_halt,
  input wire logic i_want_bus,
  output logic o_ack_b,
  output logic o_bus_error_in_b,
  output logic o_halt_b,
  output logic o_req_b,
  output logic o_gack_b,
  output logic [15:0] o_rdata,
  output logic [7:0] o_cyc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r = 2'h0;
  logic retried_r = 1'b0;
  logic as_q = 1'b1;
  initial {o_ack_b, o_bus_error_in_b, o_req_b, o_gack_b, o_cyc} = {4'hf, 8'h00};
  // released data lines show the inverse, never a stale copy
  assign o_rdata = (!i_as_b && i_rw) ? RD : ~RD;
  assign o_halt_b = ~(i_halt | ~o_bus_error_in_b);
  always @(posedge i_clk) begin
    as_q <= i_as_b;
    if (!i_as_b && as_q) o_cyc <= o_cyc + 8'h01;
    if (!i_retry) retried_r <= 1'b0;
    if (i_as_b) begin
      o_ack_b <= 1'b1;
      o_bus_error_in_b <= 1'b1;
      wait_r <= 2'h0;
    end else if (wait_r != (i_slow ? 2'h3 : 2'h1)) begin
      wait_r <= wait_r + 2'h1;
    end else if (i_retry && !retried_r) begin
      o_bus_error_in_b <= 1'b0;
      retried_r <= 1'b1;
    end else begin
      o_ack_b <= 1'b0;
    end
  end
  always @(posedge i_clk) begin
    if (!i_want_bus) begin
      o_req_b <= 1'b1;
      o_gack_b <= 1'b1;
    end else if (o_gack_b && !i_grant_b) begin
      o_gack_b <= 1'b0;
      o_req_b <= 1'b1;
    end else if (o_gack_b) begin
      o_req_b <= 1'b0;
    end
  end
endmodule

//--- tb/ext_bus_retry_halt_arbitration_bench.sv
// self-checking bench for the external bus controller
module ext_bus_retry_halt_arbitration_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] RD = 16'ha5c3;
  logic i_sys_clk, i_rst_b, i_acc_req, i_acc_internal, i_acc_locked, i_acc_rw;
  logic [23:0] i_acc_addr, o_addr;
  logic [2:0] i_acc_fc, o_fc;
  logic [1:0] i_acc_siz, i_show_cycle_enable, o_byte_count_code;
  logic [15:0] i_acc_wdata, i_acc_idata, o_acc_rdata, i_data, o_data;
  logic o_acc_done, o_acc_bus_error_in, o_irq_hold, i_transfer_ack_b, i_bus_error_in_b, i_halt_b;
  logic i_bus_request_b, i_grant_acknowledge_b, o_bus_grant_b, o_address_strobe_b;
  logic o_data_strobe_b, o_locked_cycle_b, o_ctrl_oe, o_rw, o_data_oe;
  logic m_slow, m_retry, m_halt, m_bus;
  logic [7:0] m_cyc;
  int n_fail = 0;
  int num_checks = 0;
  ebr_ctrl #(.RESYNC_CYC(2), .GRANT_GAP_CYC(2)) dut (.i_sys_clk, .i_rst_b, .i_acc_req,
    .i_acc_internal, .i_acc_locked, .i_acc_rw, .i_acc_addr, .i_acc_fc, .i_acc_siz,
    .i_acc_wdata, .i_acc_idata, .o_acc_done, .o_acc_bus_error_in, .o_acc_rdata, .o_irq_hold,
    .i_show_cycle_enable, .i_transfer_ack_b, .i_bus_error_in_b, .i_halt_b, .i_bus_request_b,
    .i_grant_acknowledge_b, .o_bus_grant_b, .o_address_strobe_b, .o_data_strobe_b,
    .o_locked_cycle_b, .o_ctrl_oe, .o_addr, .o_fc, .o_byte_count_code, .o_rw, .i_data,
    .o_data, .o_data_oe);
  ebr_far_model #(.RD(RD)) far (.i_clk(i_sys_clk), .i_as_b(o_address_strobe_b), .i_rw(o_rw),
    .i_grant_b(o_bus_grant_b), .i_slow(m_slow), .i_retry(m_retry), .i_halt(m_halt),
    .i_want_bus(m_bus), .o_ack_b(i_transfer_ack_b), .o_bus_error_in_b(i_bus_error_in_b),
    .o_halt_b(i_halt_b), .o_req_b(i_bus_request_b), .o_gack_b(i_grant_acknowledge_b),
    .o_rdata(i_data), .o_cyc(m_cyc));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request is dropped in the done cycle so it is not taken twice
  task automatic acc(input logic intl, input logic rw, input logic [23:0] a,
      input logic [1:0] sz, input logic [15:0] wd);
    int n;
    @(negedge i_sys_clk);
    {i_acc_req, i_acc_internal, i_acc_rw, i_acc_addr, i_acc_siz} = {1'b1, intl, rw, a, sz};
    i_acc_wdata = wd;
    for (n = 0; n < 60 && o_acc_done !== 1'b1; n++) @(negedge i_sys_clk);
    i_acc_req = 1'b0;
    chk("done", n < 60, 1);
  endtask
  task automatic t_ext;
    logic [7:0] c0;
    for (int s = 0; s < 2; s++) begin
      m_slow = s[0];
      c0 = m_cyc;
      acc(0, 0, 24'h01_2340, 2'h1, 16'h0077);
      chk("wr_bus_error_in", o_acc_bus_error_in, 0);
      acc(0, 1, 24'h01_2342, 2'h2, 16'h0000);
      chk("rdata", o_acc_rdata, RD);
      chk("cycles", m_cyc - c0, 2);
    end
  endtask
  task automatic t_retry;
    logic [7:0] c0;
    int n;
    for (int r = 0; r < 3; r++) begin
      m_retry = 1'b1;
      c0 = m_cyc;
      fork
        acc(0, r[0], 24'h00_4440, 2'h2, 16'hbeef);
      join_none
      // third pass: a bus request joins the failing cycle
      if (r == 2) begin
        repeat (2) @(negedge i_sys_clk);
        m_bus = 1'b1;
        for (n = 0; n < 20 && i_grant_acknowledge_b; n++) @(negedge i_sys_clk);
        chk("retry_granted", i_grant_acknowledge_b, 0);
        chk("retry_parked", m_cyc - c0, 1);
        repeat (3) @(negedge i_sys_clk);
        m_bus = 1'b0;
      end
      wait fork;
      chk("retry_bus_error_in", o_acc_bus_error_in, 0);
      chk("reruns", m_cyc - c0, 2);
      chk("rerun_addr", o_addr, 24'h00_4440);
      chk("rerun_fc", o_fc, 3'h5);
      chk("rerun_rw", o_rw, r[0]);
      chk("rerun_siz", o_byte_count_code, 2'h2);
      m_retry = 1'b0;
      @(negedge i_sys_clk);
    end
  endtask
  task automatic t_halt;
    logic [7:0] c0;
    m_halt = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    chk("irq_hold", o_irq_hold, 1);
    acc(1, 1, 24'h00_0100, 2'h2, 16'h0000);
    c0 = m_cyc;
    fork
      acc(0, 0, 24'h00_5550, 2'h2, 16'h1111);
    join_none
    repeat (12) @(negedge i_sys_clk);
    chk("halted_cyc", m_cyc - c0, 0);
    m_halt = 1'b0;
    wait fork;
    chk("resumed_cyc", m_cyc - c0, 1);
    chk("irq_free", o_irq_hold, 0);
  endtask
  task automatic t_lock;
    int n;
    i_acc_locked = 1'b1;
    // request only, halt kept negated during the locked cycle
    m_bus = 1'b1;
    fork
      acc(0, 1, 24'h00_6660, 2'h2, 16'h0000);
    join_none
    repeat (5) @(negedge i_sys_clk);
    chk("locked", o_locked_cycle_b, 0);
    chk("no_grant", o_bus_grant_b, 1);
    wait fork;
    i_acc_locked = 1'b0;
    for (n = 0; n < 20 && i_grant_acknowledge_b; n++) @(negedge i_sys_clk);
    chk("late_grant", i_grant_acknowledge_b, 0);
    chk("unlocked", o_locked_cycle_b, 1);
    m_bus = 1'b0;
    repeat (8) @(negedge i_sys_clk);
  endtask
  task automatic t_arb;
    logic [23:0] a0;
    int n;
    for (int h = 0; h < 2; h++) begin
      m_halt = h[0];
      a0 = o_addr;
      m_bus = 1'b1;
      for (n = 0; n < 20 && i_grant_acknowledge_b; n++) @(negedge i_sys_clk);
      chk("granted", i_grant_acknowledge_b, 0);
      repeat (6) @(negedge i_sys_clk);
      chk("ctrl_oe", o_ctrl_oe, 0);
      chk("grant_gone", o_bus_grant_b, 1);
      m_bus = 1'b0;
      repeat (6) @(negedge i_sys_clk);
      chk("ctrl_back", o_ctrl_oe, 1);
      chk("addr_back", o_addr, a0);
    end
    m_halt = 1'b0;
  endtask
  task automatic t_show;
    int n;
    for (int c = 0; c < 4; c++) begin
      i_show_cycle_enable = c[1:0];
      i_acc_idata = 16'h3c50 + 16'(c);
      repeat (3) @(negedge i_sys_clk);
      fork
        acc(1, 0, 24'h00_0200 + 24'(2 * c), 2'h2, 16'h0000);
      join_none
      for (n = 0; n < 4 && o_data_strobe_b; n++) @(negedge i_sys_clk);
      chk("show_ds", o_data_strobe_b, c == 0);
      chk("show_as", o_address_strobe_b, 1);
      chk("show_oe", o_data_oe, c != 0);
      if (c != 0) chk("show_data", o_data, i_acc_idata);
      wait fork;
      chk("show_addr", o_addr, 24'h00_0200 + 24'(2 * c));
    end
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // whole run needs well under a thousand cycles
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {i_acc_req, i_acc_internal, i_acc_locked, i_acc_rw, i_rst_b} = 5'h00;
    {i_acc_addr, i_acc_siz, i_acc_wdata, i_acc_idata} = '0;
    {i_show_cycle_enable, m_slow, m_retry, m_halt, m_bus} = 6'h00;
    i_acc_fc = 3'h5;
    repeat (3) @(negedge i_sys_clk);
    chk("rst_pins", {o_address_strobe_b, o_data_strobe_b, o_bus_grant_b, o_data_oe}, 4'he);
    i_rst_b = 1'b1;
    t_ext();
    t_retry();
    t_halt();
    t_arb();
    t_lock();
    t_show();
    wrap_up();
  end
endmodule
